/* include/ebw_pkg.sv */
`default_nettype none
package ebw_pkg;
  localparam logic [3:0] DEV_CODE = 4'ha;   // arbitrary device code
  localparam int WRITE_TIME_NS = 5000000;   // self-timed write duration
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int ADDR_BITS = 4;
  localparam int MEM_WORDS = 16;
  localparam int RW_BIT = 0;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 4;
  typedef enum {
    ST_IDLE, ST_CTRL, ST_ADDR, ST_DATA, ST_IGNORE
  } ebw_state_type;
endpackage
`default_nettype wire

/* include/ebw_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
// conditions decoded from the synchronised bus lines
interface ebw_link_if;
  logic start;
  logic stop;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  modport det (output start, output stop, output scl_rise, output scl_fall, output sda);
  modport core (input start, input stop, input scl_rise, input scl_fall, input sda);
endinterface
`default_nettype wire

/* core/ebw_line_det.sv */
`timescale 1ns/10ps
`default_nettype none
module ebw_line_det (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  ebw_link_if.det lnk
);
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_d1_q;
  logic sda_d1_q;

  // two-flop synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
    end
  end

  // previous synchronised values for edge finding
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_s_q[1];
      sda_d1_q <= sda_s_q[1];
    end
  end

  // start: data falls with clock high; stop: data rises with clock high
  assign lnk.start = scl_s_q[1] && scl_d1_q && sda_d1_q && !sda_s_q[1];
  assign lnk.stop = scl_s_q[1] && scl_d1_q && !sda_d1_q && sda_s_q[1];
  assign lnk.scl_rise = scl_s_q[1] && !scl_d1_q;
  assign lnk.scl_fall = !scl_s_q[1] && scl_d1_q;
  assign lnk.sda = sda_s_q[1];
endmodule
`default_nettype wire

/* core/ebw_slave.sv */
// Contract
// - acknowledge the control byte on ninth clock, then take address byte
// - address pointer loads low four bits only; address byte acknowledged
// - data byte acknowledged; following stop launches the internal write
// - no acknowledge to any byte while the internal write runs
// - address pointer stays on the written location after the write
// - stop before sequence complete aborts; memory untouched
// - bits beyond eight restart filling the data buffer
// - stop inside a later partial byte of up to six bits aborts, writes nothing
// - after write finishes, polled control byte is acknowledged
`timescale 1ns/10ps
`default_nettype none
module ebw_slave #(
  parameter int WRITE_CYCLES = ebw_pkg::WRITE_CYCLES,
  parameter int MEM_WORDS = ebw_pkg::MEM_WORDS
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  output logic WRITE_BUSY,
  output logic [3:0] ADDR_PTR,
  output logic [7:0] LAST_WRITTEN
);
  // counter wide enough to hold the full write duration
  localparam int CW = $clog2(WRITE_CYCLES + 1);

  // a zero-length write would never suppress acknowledges
  if (WRITE_CYCLES < 1) begin : g_bad_cycles
    $error("ebw_slave: write duration must be at least one cycle");
  end

  // the pointer is four bits wide, so the array must match it exactly
  if (MEM_WORDS != (1 << ebw_pkg::ADDR_BITS)) begin : g_bad_words
    $error("ebw_slave: memory depth must match the address pointer");
  end

  ebw_link_if lnk ();

  ebw_line_det u_det (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .scl_in(SCL_I),
    .sda_in(SDA_I),
    .lnk(lnk)
  );

  // protocol position within the current frame
  ebw_pkg::ebw_state_type state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic ack_phase_q;
  logic ack_drive_q;

  // write path: pointer, pending byte and the array behind it
  logic [3:0] ptr_q;
  logic [7:0] data_q;
  logic data_full_q;
  logic [7:0] mem_q [MEM_WORDS];

  // self-timed write
  logic [CW-1:0] busy_cnt_q;

  // decoded strobes from the current bus state
  logic [7:0] shift_d;
  logic byte_done;
  logic busy;
  logic at_boundary;
  logic launch;
  logic ctrl_ok;
  logic ack_ok;

  // the internal write runs while the counter is non-zero
  assign busy = busy_cnt_q != '0;
  // bits arrive msb first and are taken on each clock rise outside the ack slot
  assign shift_d = {shift_q[6:0], lnk.sda};
  // eighth bit of a byte; the ack clock that follows is not shifted
  assign byte_done = lnk.scl_rise && !ack_phase_q && bit_cnt_q == 4'h7;
  // write code low and matching device code; don't-care bits skipped
  assign ctrl_ok = shift_d[ebw_pkg::CODE_MSB:ebw_pkg::CODE_LSB] == ebw_pkg::DEV_CODE
                   && !shift_d[ebw_pkg::RW_BIT];
  // only an accepted control byte and the bytes after it are answered
  assign ack_ok = state_q == ebw_pkg::ST_ADDR || state_q == ebw_pkg::ST_DATA;
  // a stop follows one clock rise that the shifter counts as a bit unless it is the ack clock,
  // so a finished byte leaves a count of zero or one; more is a cut byte
  assign at_boundary = bit_cnt_q <= 4'h1;
  // stop only launches a write after a whole byte was taken
  assign launch = lnk.stop && state_q == ebw_pkg::ST_DATA && data_full_q && at_boundary;

  // protocol state machine
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ebw_pkg::ST_IDLE;
    end else if (lnk.start) begin
      // a start always wins, even mid-byte, and re-arms the frame
      state_q <= ebw_pkg::ST_CTRL;
    end else if (lnk.stop) begin
      state_q <= ebw_pkg::ST_IDLE;
    end else if (byte_done) begin
      case (state_q)
        ebw_pkg::ST_CTRL: begin
          // busy or foreign code: stay silent until next start
          state_q <= (ctrl_ok && !busy) ? ebw_pkg::ST_ADDR : ebw_pkg::ST_IGNORE;
        end
        ebw_pkg::ST_ADDR: begin
          state_q <= ebw_pkg::ST_DATA;
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // bit counter and shifter; ack slot follows every eighth bit
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      ack_phase_q <= 1'b0;
    end else if (lnk.start || lnk.stop) begin
      // a start or stop re-aligns the counter to a byte boundary
      bit_cnt_q <= 4'h0;
      ack_phase_q <= 1'b0;
    end else if (lnk.scl_rise) begin
      if (ack_phase_q) begin
        ack_phase_q <= 1'b0;
      end else begin
        shift_q <= shift_d;
        bit_cnt_q <= byte_done ? 4'h0 : bit_cnt_q + 4'h1;
        ack_phase_q <= byte_done;
      end
    end
  end

  // acknowledge driven low across the ninth clock
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_drive_q <= 1'b0;
    end else if (lnk.start || lnk.stop) begin
      ack_drive_q <= 1'b0;
    end else if (lnk.scl_fall) begin
      // released on a falling clock so the line never moves while clock is high
      ack_drive_q <= 1'b0;
      if (ack_phase_q && bit_cnt_q == 4'h0) begin
        // ack slot just opened: answer for accepted bytes only
        ack_drive_q <= ack_ok;
      end
    end
  end

  // address pointer: upper four bits of the address byte are dropped
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr_q <= 4'h0;
    end else if (byte_done && state_q == ebw_pkg::ST_ADDR) begin
      ptr_q <= shift_d[ebw_pkg::ADDR_BITS-1:0];
    end
  end

  // data register: later bytes replace earlier ones
  // the pending flag is cleared by a new start so a stale byte never lands
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      data_q <= 8'h00;
      data_full_q <= 1'b0;
    end else if (lnk.start) begin
      data_full_q <= 1'b0;
    end else if (byte_done && state_q == ebw_pkg::ST_DATA) begin
      data_q <= shift_d;
      data_full_q <= 1'b1;
    end
  end

  // self-timed write counter; pointer left alone afterwards
  // no relaunch while busy: no control byte is accepted during the count
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      busy_cnt_q <= '0;
    end else if (launch) begin
      busy_cnt_q <= CW'(WRITE_CYCLES);
    end else if (busy) begin
      busy_cnt_q <= busy_cnt_q - CW'(1);
    end
  end

  // memory array written once at launch
  always_ff @(posedge SYS_CLK) begin
    if (launch) begin
      mem_q[ptr_q] <= data_q;
    end
  end

  // bus-side outputs; the pin is open drain, so only a low is ever driven
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SDA_O <= 1'b1;
      SDA_OE <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
      SDA_OE <= ack_drive_q;
    end
  end

  // status outputs; the memory itself has no reset, so its word may read
  // unknown until that location has been written once
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WRITE_BUSY <= 1'b0;
      ADDR_PTR <= 4'h0;
      LAST_WRITTEN <= 8'h00;
    end else begin
      WRITE_BUSY <= busy;
      ADDR_PTR <= ptr_q;
      LAST_WRITTEN <= mem_q[ptr_q];
    end
  end
endmodule
`default_nettype wire

/* tb/ebw_slave_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module ebw_slave_assertions #(
  parameter int WRITE_CYCLES = ebw_pkg::WRITE_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic WRITE_BUSY,
  input wire logic [3:0] ADDR_PTR,
  input wire logic [7:0] LAST_WRITTEN
);
  int busy_cnt;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // busy length, checked when it ends
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N)
      busy_cnt <= 0;
    else
      busy_cnt <= WRITE_BUSY ? busy_cnt + 1 : 0;
  end
  sequence ack_phase; SDA_OE [*8]; endsequence
  sequence bus_idle; SCL_I && SDA_I; endsequence
  busy_no_ack_a: assert property (WRITE_BUSY |-> !SDA_OE)
    else $error("ack during write");
  ack_low_a: assert property (SDA_OE |-> !SDA_O)
    else $error("ack not low");
  ack_start_a: assert property ($rose(SDA_OE) |-> !SCL_I ##0 ack_phase)
    else $error("ack too short");
  ack_end_a: assert property ($fell(SDA_OE) |-> !SCL_I)
    else $error("ack left with clock high");
  ptr_hold_a: assert property (WRITE_BUSY ##1 WRITE_BUSY |-> $stable(ADDR_PTR))
    else $error("pointer moved in write");
  ptr_frozen_a: assert property ($changed(ADDR_PTR) |-> !WRITE_BUSY)
    else $error("pointer loaded in write");
  busy_len_a: assert property ($fell(WRITE_BUSY) |-> busy_cnt == WRITE_CYCLES)
    else $error("write length wrong");
  busy_idle_a: assert property ($rose(WRITE_BUSY) |-> bus_idle)
    else $error("write began off a stop");
endmodule
bind ebw_slave ebw_slave_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O),
  .SDA_OE(SDA_OE), .WRITE_BUSY(WRITE_BUSY), .ADDR_PTR(ADDR_PTR), .LAST_WRITTEN(LAST_WRITTEN));
`default_nettype wire

/* tb/ebw_bus_master.sv */
`timescale 1ns/10ps
`default_nettype none
module ebw_bus_master (
  input wire logic clk,
  output logic scl,
  output logic sda,
  input wire logic line
);
  // idle high; clock stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic q;
    repeat (4) @(posedge clk);
  endtask
  // data moves only while the clock is low; 1 releases the pulled-up line
  task automatic bit_x(input logic b, output logic r);
    sda <= b;
    q;
    scl <= 1'b1;
    q;
    r = line;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic start;
    q;
    sda <= 1'b0;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic stop;
    sda <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda <= 1'b1;
    q;
    q;
  endtask
  // n bits msb first; a whole byte also gets its ack slot
  task automatic send(input logic [7:0] v, input int n, output logic ack);
    logic r;
    for (int i = 7; i > 7 - n; i--)
      bit_x(v[i], r);
    ack = 1'b0;
    if (n == 8) begin
      bit_x(1'b1, r);
      ack = !r;
    end
  endtask
endmodule
`default_nettype wire

/* tb/ebw_slave_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ebw_slave_tb;
  logic clk, rst_n, ack, scl, msda, oe, so, busy;
  logic [3:0] ptr;
  logic [7:0] last;
  int failures, tests_run, cyc;
  wire logic sda_w = msda & ~(oe & ~so);
  always #5 clk = ~clk;
  ebw_bus_master u_mst (.clk(clk), .scl(scl), .sda(msda), .line(sda_w));
  ebw_slave #(.WRITE_CYCLES(300)) u_dut (.SYS_CLK(clk), .RST_N(rst_n), .SCL_I(scl),
    .SDA_I(sda_w), .SDA_O(so), .SDA_OE(oe), .WRITE_BUSY(busy), .ADDR_PTR(ptr),
    .LAST_WRITTEN(last));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic ctrl(input logic [7:0] c, input logic exp);
    u_mst.start;
    u_mst.send(c, 8, ack);
    chk(ack, exp);
  endtask
  task automatic cmd(input logic [7:0] a);
    ctrl(8'ha0, 1'b1);
    u_mst.send(a, 8, ack);
    chk(ack, 1);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++)
      @(posedge clk);
    chk(busy, 0);
  endtask
  task automatic t_write;
    cmd(8'h35);
    u_mst.send(8'h5a, 8, ack);
    chk(ack, 1);
    chk(ptr, 8'h05);
    u_mst.stop;
    chk(busy, 1);
    ctrl(8'ha0, 1'b0);
    u_mst.stop;
    wait_idle;
    chk(last, 8'h5a);
    chk(ptr, 8'h05);
    ctrl(8'ha0, 1'b1);
    u_mst.stop;
    $display("write and poll done");
  endtask
  task automatic t_abort;
    cmd(8'hf5);
    u_mst.stop;
    chk(busy, 0);
    chk(last, 8'h5a);
    $display("abort done");
  endtask
  task automatic t_replace;
    cmd(8'h05);
    u_mst.send(8'h11, 8, ack);
    u_mst.send(8'hc3, 8, ack);
    chk(ack, 1);
    u_mst.stop;
    wait_idle;
    chk(last, 8'hc3);
    $display("replace done");
  endtask
  task automatic t_partial;
    cmd(8'h05);
    u_mst.send(8'h77, 8, ack);
    u_mst.send(8'h90, 4, ack);
    u_mst.stop;
    chk(busy, 0);
    chk(last, 8'hc3);
    ctrl(8'h30, 1'b0);
    u_mst.stop;
    ctrl(8'ha1, 1'b0);
    u_mst.stop;
    $display("partial and refusals done");
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      report_and_stop;
    end
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    failures = 0;
    tests_run = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_write;
    t_abort;
    t_replace;
    t_partial;
    report_and_stop;
  end
endmodule
`default_nettype wire
